// File: core/fhp_defs.svh
// constants shared by both ends of the flash host port front end
`ifndef FHP_DEFS_SVH
`define FHP_DEFS_SVH
`define FHP_START_LPC 4'h0
`define FHP_START_HUB_RD 4'hd
`define FHP_START_HUB_WR 4'he
`define FHP_ABORT_NIB 4'hf
`define FHP_LANE_IDLE 4'hf
`define FHP_DATA_IDLE 8'hff
`define FHP_LPC_MEM_TYPE 2'h1
`define FHP_LPC_TYPE_MSB 3
`define FHP_LPC_TYPE_LSB 2
`define FHP_LPC_DIR_BIT 1
`define FHP_BOOT_ID 4'h0
`define FHP_RDY_BIT 7
`define FHP_ROW_W 11
`define FHP_COL_W 7
`define FHP_ADDR_W 18
`define FHP_CLK_MHZ 100
`define FHP_PHASE_NS 80
`define FHP_PHASE_CYC ((`FHP_PHASE_NS * `FHP_CLK_MHZ + 999) / 1000)
`define FHP_ABORT_CYC 4
`define FHP_CNT_W 8
`endif

// File: core/fhp_pkg.sv
// types shared by both ends of the flash host port front end
package fhp_pkg;
  // device nibble bus states
  typedef enum logic [2:0] {
    FHP_D_IDLE = 3'b001,
    FHP_D_FRAME = 3'b010,
    FHP_D_CLAIM = 3'b100
  } fhp_dstate_e;
  // decoded cycle kinds
  typedef enum logic [1:0] {
    FHP_K_LPC_MEM = 2'h0,
    FHP_K_HUB_RD = 2'h1,
    FHP_K_HUB_WR = 2'h2,
    FHP_K_NONE = 2'h3
  } fhp_kind_e;
  // host end states
  typedef enum logic [9:0] {
    FHP_H_IDLE = 10'h001,
    FHP_H_START = 10'h002,
    FHP_H_FIELD = 10'h004,
    FHP_H_ABORT = 10'h008,
    FHP_H_ROW = 10'h010,
    FHP_H_FALL = 10'h020,
    FHP_H_COL = 10'h040,
    FHP_H_RISE = 10'h080,
    FHP_H_ACC = 10'h100,
    FHP_H_END = 10'h200
  } fhp_hstate_e;
  // device state, all but the field nibble register
  typedef struct packed {
    fhp_dstate_e dstate;
    logic [3:0] start_nib;
    fhp_kind_e kind;
    logic wr;
    logic valid;
    logic lane_oe;
    logic [3:0] lane_o;
    logic [2:0] strap_s;
    logic [2:0] rc_s;
    logic [2:0] oe_s;
    logic [2:0] we_s;
    logic strap_f;
    logic rc_f;
    logic oe_f;
    logic we_f;
    logic [11:0] id_s;
    logic [3:0] id_f;
    logic [32:0] addr_s;
    logic [23:0] data_s;
    logic [10:0] row;
    logic [6:0] col;
    logic [7:0] wdata;
    logic prog_wr;
    logic [7:0] dout;
    logic doe;
    logic rdy;
  } fhp_dev_s;
  // whole host state
  typedef struct packed {
    fhp_hstate_e hstate;
    logic [7:0] cnt;
    logic frame_n;
    logic [3:0] lane_o;
    logic lane_oe;
    logic [3:0] lanes_seen;
    logic [10:0] addr_o;
    logic rc;
    logic oe_n;
    logic we_n;
    logic [7:0] data_o;
    logic data_oe;
    logic [7:0] rdata;
    logic done;
  } fhp_host_s;
endpackage

// File: core/fhp_if.sv
// pin level meeting point of the device end and the host end
`include "fhp_defs.svh"
interface fhp_if;
  logic interface_select_strap; // high selects programming port
  logic frame_strobe_n; // frame strobe, low active
  logic [3:0] host_lane_o; // host lane drive value
  logic host_lane_oe; // host drives lanes
  logic [3:0] dev_lane_o; // device lane drive value
  logic dev_lane_oe; // device drives lanes
  logic [3:0] nibble_lanes; // resolved lane level
  logic [3:0] strap_select_inputs; // board id straps
  logic [10:0] mux_addr; // multiplexed address pins
  logic row_col_strobe; // row on fall, column on rise
  logic out_enable_n; // programming read enable
  logic write_enable_n; // programming write enable
  logic [7:0] prog_data_o; // programmer data drive
  logic prog_data_oe; // programmer drives data
  logic [7:0] dev_data_o; // device data drive
  logic dev_data_oe; // device drives data
  logic [7:0] mux_data; // resolved data level
  logic ready_busy_out; // device ready/busy pin
  // pulled up lanes when nobody drives
  assign nibble_lanes = dev_lane_oe ? dev_lane_o :
                        host_lane_oe ? host_lane_o : `FHP_LANE_IDLE;
  // pulled up data pins when nobody drives
  assign mux_data = dev_data_oe ? dev_data_o :
                    prog_data_oe ? prog_data_o : `FHP_DATA_IDLE;
  modport device (
    input interface_select_strap, frame_strobe_n, nibble_lanes,
    input strap_select_inputs, mux_addr, row_col_strobe,
    input out_enable_n, write_enable_n, mux_data,
    output dev_lane_o, dev_lane_oe, dev_data_o, dev_data_oe,
    output ready_busy_out
  );
  modport host (
    input nibble_lanes, mux_data, ready_busy_out,
    output interface_select_strap, frame_strobe_n, host_lane_o,
    output host_lane_oe, strap_select_inputs, mux_addr,
    output row_col_strobe, out_enable_n, write_enable_n,
    output prog_data_o, prog_data_oe
  );
endinterface

// File: core/fhp_device.sv
// device end: interface select, start decode, programming port pins
`include "fhp_defs.svh"
module fhp_device (
  input wire logic clock, // host bus clock
  input wire logic rst, // synchronous reset, high
  input wire logic clk_en, // freezes all state when low
  fhp_if.device bus, // pin side
  input wire logic cyc_done, // user ends claimed cycle
  input wire logic lane_drive_req, // user wants lanes driven
  input wire logic [3:0] lane_data, // nibble to drive
  input wire logic op_busy, // internal operation running
  input wire logic [7:0] status_in, // internal status byte
  input wire logic [7:0] prog_rdata, // read data for port
  output logic prog_mode, // programming port selected
  output logic full_feature_en, // protection features open
  output logic cycle_valid, // one pulse per claimed cycle
  output fhp_pkg::fhp_kind_e cycle_kind, // decoded kind
  output logic cycle_write, // claimed cycle writes
  output logic claimed, // a cycle is in progress
  output logic standby, // idle, frame high, no operation
  output logic [3:0] field_nib, // nibble after start
  output logic prog_wr, // one pulse per port write
  output logic [`FHP_ADDR_W-1:0] prog_addr, // latched address
  output logic [7:0] prog_wdata // latched write data
);
  fhp_pkg::fhp_dev_s st_r; // registered state
  fhp_pkg::fhp_dev_s st_nxt; // next state
  logic frame_low; // frame sampled active
  logic [3:0] lanes; // lane level this clock
  logic [10:0] addr_s3; // third address stage
  logic [7:0] data_s3; // third data stage

  // frame and lanes are on this clock, no sync
  assign frame_low = ~bus.frame_strobe_n;
  assign lanes = bus.nibble_lanes;
  assign addr_s3 = st_r.addr_s[32:22];
  assign data_s3 = st_r.data_s[23:16];

  // next state of everything
  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    st_nxt.prog_wr = 1'b0;
    st_nxt.lane_oe = 1'b0;
    // three stage pin synchronisers
    st_nxt.strap_s = {st_r.strap_s[1:0], bus.interface_select_strap};
    st_nxt.rc_s = {st_r.rc_s[1:0], bus.row_col_strobe};
    st_nxt.oe_s = {st_r.oe_s[1:0], bus.out_enable_n};
    st_nxt.we_s = {st_r.we_s[1:0], bus.write_enable_n};
    st_nxt.id_s = {st_r.id_s[7:0], bus.strap_select_inputs};
    st_nxt.addr_s = {st_r.addr_s[21:0], bus.mux_addr};
    st_nxt.data_s = {st_r.data_s[15:0], bus.mux_data};
    // a change counts once stages two and three agree
    if (st_r.strap_s[1] == st_r.strap_s[2]) begin
      st_nxt.strap_f = st_r.strap_s[2];
    end
    if (st_r.rc_s[1] == st_r.rc_s[2]) begin
      st_nxt.rc_f = st_r.rc_s[2];
    end
    if (st_r.oe_s[1] == st_r.oe_s[2]) begin
      st_nxt.oe_f = st_r.oe_s[2];
    end
    if (st_r.we_s[1] == st_r.we_s[2]) begin
      st_nxt.we_f = st_r.we_s[2];
    end
    if (st_r.id_s[7:4] == st_r.id_s[11:8]) begin
      st_nxt.id_f = st_r.id_s[11:8];
    end
    // programming port, only while strap high
    if (st_r.strap_f) begin
      // falling strobe takes the row
      if (st_r.rc_f && !st_nxt.rc_f) begin
        st_nxt.row = addr_s3;
      end
      // rising strobe takes the column
      if (!st_r.rc_f && st_nxt.rc_f) begin
        st_nxt.col = addr_s3[6:0];
      end
      // write enable release latches data
      if (!st_r.we_f && st_nxt.we_f) begin
        st_nxt.wdata = data_s3;
        st_nxt.prog_wr = 1'b1;
      end
    end
    // drive data only under output enable, write idle
    st_nxt.doe = st_nxt.strap_f && !st_nxt.oe_f && st_nxt.we_f;
    st_nxt.dout = prog_rdata;
    // ready/busy copies the completion bit
    st_nxt.rdy = status_in[`FHP_RDY_BIT];
    // nibble bus, held idle while port selected
    if (st_r.strap_f) begin
      st_nxt.dstate = fhp_pkg::FHP_D_IDLE;
      st_nxt.kind = fhp_pkg::FHP_K_NONE;
    end else begin
      case (st_r.dstate)
        // wait for frame
        fhp_pkg::FHP_D_IDLE: begin
          if (frame_low) begin
            st_nxt.dstate = fhp_pkg::FHP_D_FRAME;
            st_nxt.start_nib = lanes;
          end
        end
        // frame low: keep newest start nibble
        fhp_pkg::FHP_D_FRAME: begin
          if (frame_low) begin
            st_nxt.start_nib = lanes;
          end else begin
            st_nxt.dstate = fhp_pkg::FHP_D_IDLE;
            st_nxt.kind = fhp_pkg::FHP_K_NONE;
            case (st_r.start_nib)
              // lpc: memory only, else ignore
              `FHP_START_LPC: begin
                if (lanes[`FHP_LPC_TYPE_MSB:`FHP_LPC_TYPE_LSB] ==
                    `FHP_LPC_MEM_TYPE) begin
                  st_nxt.dstate = fhp_pkg::FHP_D_CLAIM;
                  st_nxt.kind = fhp_pkg::FHP_K_LPC_MEM;
                  st_nxt.wr = lanes[`FHP_LPC_DIR_BIT];
                  st_nxt.valid = 1'b1;
                end
              end
              // hub read: claim when id matches
              `FHP_START_HUB_RD: begin
                if (lanes == st_r.id_f) begin
                  st_nxt.dstate = fhp_pkg::FHP_D_CLAIM;
                  st_nxt.kind = fhp_pkg::FHP_K_HUB_RD;
                  st_nxt.wr = 1'b0;
                  st_nxt.valid = 1'b1;
                end
              end
              // hub write: claim when id matches
              `FHP_START_HUB_WR: begin
                if (lanes == st_r.id_f) begin
                  st_nxt.dstate = fhp_pkg::FHP_D_CLAIM;
                  st_nxt.kind = fhp_pkg::FHP_K_HUB_WR;
                  st_nxt.wr = 1'b1;
                  st_nxt.valid = 1'b1;
                end
              end
              // invalid start: stay off lanes
              default: begin
                st_nxt.kind = fhp_pkg::FHP_K_NONE;
              end
            endcase
          end
        end
        // claimed: frame low aborts, lanes dropped
        fhp_pkg::FHP_D_CLAIM: begin
          if (frame_low) begin
            st_nxt.dstate = fhp_pkg::FHP_D_FRAME;
            st_nxt.start_nib = lanes;
            st_nxt.kind = fhp_pkg::FHP_K_NONE;
          end else if (cyc_done) begin
            st_nxt.dstate = fhp_pkg::FHP_D_IDLE;
            st_nxt.kind = fhp_pkg::FHP_K_NONE;
          end else begin
            st_nxt.lane_oe = lane_drive_req;
            st_nxt.lane_o = lane_data;
          end
        end
        // recover from a broken code
        default: begin
          st_nxt.dstate = fhp_pkg::FHP_D_IDLE;
        end
      endcase
    end
  end

  // register the state, frozen without enable
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
      st_r.dstate <= fhp_pkg::FHP_D_IDLE;
      st_r.kind <= fhp_pkg::FHP_K_NONE;
      st_r.start_nib <= `FHP_LANE_IDLE;
      st_r.lane_o <= `FHP_LANE_IDLE;
      st_r.id_f <= `FHP_BOOT_ID;
      st_r.rc_s <= 3'h7;
      st_r.oe_s <= 3'h7;
      st_r.we_s <= 3'h7;
      st_r.rc_f <= 1'b1;
      st_r.oe_f <= 1'b1;
      st_r.we_f <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // field nibble kept from the decode clock
  logic [3:0] field_r; // nibble following start
  always_ff @(posedge clock) begin
    if (rst) begin
      field_r <= 4'h0;
    end else if (clk_en && st_r.dstate == fhp_pkg::FHP_D_FRAME &&
                 !frame_low) begin
      field_r <= lanes;
    end
  end

  // pins and user side
  assign bus.dev_lane_o = st_r.lane_o;
  assign bus.dev_lane_oe = st_r.lane_oe;
  assign bus.dev_data_o = st_r.dout;
  assign bus.dev_data_oe = st_r.doe;
  assign bus.ready_busy_out = st_r.rdy;
  assign prog_mode = st_r.strap_f;
  assign full_feature_en = ~st_r.strap_f;
  assign cycle_valid = st_r.valid;
  assign cycle_kind = st_r.kind;
  assign cycle_write = st_r.wr;
  assign claimed = (st_r.dstate == fhp_pkg::FHP_D_CLAIM);
  // standby: idle, frame high, nothing running
  assign standby = (st_r.dstate == fhp_pkg::FHP_D_IDLE) &&
                   !frame_low && !op_busy && !st_r.strap_f;
  assign field_nib = field_r;
  assign prog_wr = st_r.prog_wr;
  assign prog_addr = {st_r.col, st_r.row};
  assign prog_wdata = st_r.wdata;
endmodule

// File: core/fhp_host.sv
// host end: cycle header and abort, programming port sequencer
`include "fhp_defs.svh"
module fhp_host (
  input wire logic clock, // host bus clock
  input wire logic rst, // synchronous reset, high
  input wire logic clk_en, // freezes all state when low
  fhp_if.host bus, // pin side
  input wire logic mode_sel, // strap level to present
  input wire logic [3:0] id_strap, // id straps to present
  input wire logic cmd_start, // send start and field
  input wire logic [3:0] cmd_start_nib, // start nibble
  input wire logic [3:0] cmd_field_nib, // following nibble
  input wire logic cmd_abort, // abort current cycle
  input wire logic prog_go, // run a port access
  input wire logic prog_write, // access writes
  input wire logic [`FHP_ADDR_W-1:0] prog_addr, // address
  input wire logic [7:0] prog_wdata, // write data
  output logic busy, // sequencer not idle
  output logic done, // one pulse at end of job
  output logic [7:0] prog_rdata, // read data
  output logic [3:0] lanes_seen, // lane level last clock
  output logic ready_busy // device ready/busy seen
);
  localparam logic [7:0] PHASE = 8'(`FHP_PHASE_CYC);
  localparam logic [7:0] ABORT = 8'(`FHP_ABORT_CYC);
  fhp_pkg::fhp_host_s st_r; // registered state
  fhp_pkg::fhp_host_s st_nxt; // next state
  logic last; // phase count ran out

  assign last = (st_r.cnt == 8'h01);

  // next state of the sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.lanes_seen = bus.nibble_lanes;
    if (st_r.cnt != 8'h00) begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
    case (st_r.hstate)
      // idle: abort first, then start, then port
      fhp_pkg::FHP_H_IDLE: begin
        st_nxt.frame_n = 1'b1;
        st_nxt.lane_oe = 1'b0;
        if (cmd_abort) begin
          st_nxt.hstate = fhp_pkg::FHP_H_ABORT;
          st_nxt.frame_n = 1'b0;
          st_nxt.lane_o = `FHP_ABORT_NIB;
          st_nxt.lane_oe = 1'b1;
          st_nxt.cnt = ABORT;
        end else if (cmd_start) begin
          st_nxt.hstate = fhp_pkg::FHP_H_START;
          st_nxt.frame_n = 1'b0;
          st_nxt.lane_o = cmd_start_nib;
          st_nxt.lane_oe = 1'b1;
        end else if (prog_go) begin
          st_nxt.hstate = fhp_pkg::FHP_H_ROW;
          st_nxt.addr_o = prog_addr[10:0];
          st_nxt.rc = 1'b1;
          st_nxt.data_o = prog_wdata;
          // write flag kept in data drive, write enable idle until access
          st_nxt.data_oe = prog_write;
          st_nxt.cnt = PHASE;
        end
      end
      // start nibble under frame low
      fhp_pkg::FHP_H_START: begin
        st_nxt.hstate = fhp_pkg::FHP_H_FIELD;
        st_nxt.frame_n = 1'b1;
        st_nxt.lane_o = cmd_field_nib;
      end
      // one field nibble then release
      fhp_pkg::FHP_H_FIELD: begin
        st_nxt.hstate = fhp_pkg::FHP_H_IDLE;
        st_nxt.lane_oe = 1'b0;
        st_nxt.done = 1'b1;
      end
      // frame held low for the abort
      fhp_pkg::FHP_H_ABORT: begin
        if (last) begin
          st_nxt.hstate = fhp_pkg::FHP_H_IDLE;
          st_nxt.frame_n = 1'b1;
          st_nxt.lane_oe = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
      // row shown, strobe high, then fall
      fhp_pkg::FHP_H_ROW: begin
        if (last) begin
          st_nxt.hstate = fhp_pkg::FHP_H_FALL;
          st_nxt.rc = 1'b0;
          st_nxt.cnt = PHASE;
        end
      end
      // row held past the fall, column next
      fhp_pkg::FHP_H_FALL: begin
        if (last) begin
          st_nxt.hstate = fhp_pkg::FHP_H_COL;
          st_nxt.addr_o = {4'h0, prog_addr[17:11]};
          st_nxt.cnt = PHASE;
        end
      end
      // column set up, then rise
      fhp_pkg::FHP_H_COL: begin
        if (last) begin
          st_nxt.hstate = fhp_pkg::FHP_H_RISE;
          st_nxt.rc = 1'b1;
          st_nxt.cnt = PHASE;
        end
      end
      // column held, then strobe access
      fhp_pkg::FHP_H_RISE: begin
        if (last) begin
          st_nxt.hstate = fhp_pkg::FHP_H_ACC;
          // read: output enable low; write: write enable low
          st_nxt.oe_n = st_r.data_oe;
          st_nxt.we_n = ~st_r.data_oe;
          st_nxt.cnt = PHASE;
        end
      end
      // write enable or output enable low
      fhp_pkg::FHP_H_ACC: begin
        st_nxt.we_n = ~st_r.data_oe;
        if (last) begin
          st_nxt.hstate = fhp_pkg::FHP_H_END;
          st_nxt.rdata = bus.mux_data;
          st_nxt.we_n = 1'b1;
          st_nxt.oe_n = 1'b1;
          st_nxt.cnt = PHASE;
        end
      end
      // hold data past the write release
      fhp_pkg::FHP_H_END: begin
        if (last) begin
          st_nxt.hstate = fhp_pkg::FHP_H_IDLE;
          st_nxt.data_oe = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
      // recover from a broken code
      default: begin
        st_nxt.hstate = fhp_pkg::FHP_H_IDLE;
      end
    endcase
  end

  // register the state, frozen without enable
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
      st_r.hstate <= fhp_pkg::FHP_H_IDLE;
      st_r.frame_n <= 1'b1;
      st_r.lane_o <= `FHP_LANE_IDLE;
      st_r.rc <= 1'b1;
      st_r.oe_n <= 1'b1;
      st_r.we_n <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // pins and user side
  assign bus.interface_select_strap = mode_sel;
  assign bus.strap_select_inputs = id_strap;
  assign bus.frame_strobe_n = st_r.frame_n;
  assign bus.host_lane_o = st_r.lane_o;
  assign bus.host_lane_oe = st_r.lane_oe;
  assign bus.mux_addr = st_r.addr_o;
  assign bus.row_col_strobe = st_r.rc;
  assign bus.out_enable_n = st_r.oe_n;
  assign bus.write_enable_n = st_r.we_n;
  assign bus.prog_data_o = st_r.data_o;
  assign bus.prog_data_oe = st_r.data_oe;
  assign busy = (st_r.hstate != fhp_pkg::FHP_H_IDLE);
  assign done = st_r.done;
  assign prog_rdata = st_r.rdata;
  assign lanes_seen = st_r.lanes_seen;
  assign ready_busy = bus.ready_busy_out;
endmodule

// File: testbench/fhp_asserts.sv
// pin level checks between the host end and the device end
module fhp_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic interface_select_strap,
  input wire logic frame_strobe_n,
  input wire logic [3:0] nibble_lanes,
  input wire logic dev_lane_oe,
  input wire logic out_enable_n,
  input wire logic write_enable_n,
  input wire logic dev_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // all checks on the one bus clock
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // last nibble under frame is no known start code
  sequence s_bad_start;
    !frame_strobe_n && !(nibble_lanes inside {4'h0, 4'hd, 4'he})
    ##1 frame_strobe_n;
  endsequence
  // read held long enough to pass the pin filters
  sequence s_read_held;
    (interface_select_strap && !out_enable_n && write_enable_n)[*8];
  endsequence
  a_frame_drops_lanes: assert property (
    !frame_strobe_n |=> !dev_lane_oe)
    else $error("lanes driven after frame low");
  a_bad_start_float: assert property (
    s_bad_start |-> !dev_lane_oe[*3])
    else $error("lanes driven after bad start");
  a_oe_high_floats: assert property (
    out_enable_n[*8] |-> !dev_data_oe)
    else $error("data driven with output enable off");
  a_oe_rise_release: assert property (
    $rose(out_enable_n) |-> ##[1:8] !dev_data_oe)
    else $error("data not released after output enable");
  a_write_no_drive: assert property (
    !write_enable_n[*8] |-> !dev_data_oe)
    else $error("data driven during write");
  a_read_drives: assert property (
    s_read_held |-> dev_data_oe)
    else $error("data not driven during read");
  a_lpc_no_data: assert property (
    !interface_select_strap[*8] |-> !dev_data_oe)
    else $error("data pins driven in nibble mode");
  a_prog_no_lanes: assert property (
    interface_select_strap[*8] |-> !dev_lane_oe)
    else $error("lanes driven in programming mode");
endmodule

// File: testbench/tb_flash_host_port_front_end.sv
// self checking bench: host end and device end face to face
`include "fhp_defs.svh"
module tb_flash_host_port_front_end;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1; // freezes both ends when low
  // device user side
  logic cyc_done = 1'b0;
  logic lane_drive_req = 1'b0;
  logic [3:0] lane_data = 4'h0;
  logic op_busy = 1'b0;
  logic [7:0] status_in = 8'h00;
  logic [7:0] d_rdata = 8'h00;
  logic prog_mode, full_feature_en, cycle_valid, cycle_write;
  logic claimed, standby, prog_wr;
  fhp_pkg::fhp_kind_e cycle_kind;
  logic [3:0] field_nib;
  logic [`FHP_ADDR_W-1:0] d_addr;
  logic [7:0] d_wdata;
  // host user side
  logic mode_sel = 1'b0;
  logic [3:0] id_strap = 4'h0;
  logic cmd_start = 1'b0;
  logic [3:0] s_nib = 4'h0;
  logic [3:0] f_nib = 4'h0;
  logic cmd_abort = 1'b0;
  logic prog_go = 1'b0;
  logic prog_write = 1'b0;
  logic [`FHP_ADDR_W-1:0] h_addr = 18'h00000;
  logic [7:0] h_wdata = 8'h00;
  logic done, ready_busy, busy;
  logic [3:0] lanes_seen;
  logic [7:0] h_rdata;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 17279;
  logic [31:0] rnd;
  logic [3:0] exp;
  logic seen;
  fhp_if u_fhp_if ();
  fhp_device u_fhp_device (
    .clock(clock), .rst(rst), .clk_en(clk_en), .bus(u_fhp_if),
    .cyc_done(cyc_done), .lane_drive_req(lane_drive_req),
    .lane_data(lane_data), .op_busy(op_busy), .status_in(status_in),
    .prog_rdata(d_rdata), .prog_mode(prog_mode),
    .full_feature_en(full_feature_en), .cycle_valid(cycle_valid),
    .cycle_kind(cycle_kind), .cycle_write(cycle_write),
    .claimed(claimed), .standby(standby), .field_nib(field_nib),
    .prog_wr(prog_wr), .prog_addr(d_addr), .prog_wdata(d_wdata));
  fhp_host u_fhp_host (
    .clock(clock), .rst(rst), .clk_en(clk_en), .bus(u_fhp_if),
    .mode_sel(mode_sel), .id_strap(id_strap), .cmd_start(cmd_start),
    .cmd_start_nib(s_nib), .cmd_field_nib(f_nib), .cmd_abort(cmd_abort),
    .prog_go(prog_go), .prog_write(prog_write), .prog_addr(h_addr),
    .prog_wdata(h_wdata), .busy(busy), .done(done), .prog_rdata(h_rdata),
    .lanes_seen(lanes_seen), .ready_busy(ready_busy));
  fhp_asserts u_fhp_asserts (
    .clock(clock), .rst(rst),
    .interface_select_strap(u_fhp_if.interface_select_strap),
    .frame_strobe_n(u_fhp_if.frame_strobe_n),
    .nibble_lanes(u_fhp_if.nibble_lanes),
    .dev_lane_oe(u_fhp_if.dev_lane_oe),
    .out_enable_n(u_fhp_if.out_enable_n),
    .write_enable_n(u_fhp_if.write_enable_n),
    .dev_data_oe(u_fhp_if.dev_data_oe));
  // bus clock, 10 ns
  always #5 clock = ~clock;
  // cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // expected {claim, write, kind} of one start
  function automatic logic [3:0] want(input logic [3:0] s, f, id,
                                      input logic pm);
    case (s)
      4'h0: want = {f[3:2] == 2'h1, f[1], fhp_pkg::FHP_K_LPC_MEM};
      4'hd: want = {f == id, 1'b0, fhp_pkg::FHP_K_HUB_RD};
      4'he: want = {f == id, 1'b1, fhp_pkg::FHP_K_HUB_WR};
      default: want = 4'h3;
    endcase
    if (pm) want[3] = 1'b0;
  endfunction
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // wait for host done, noting claim or write pulses
  task automatic wait_done();
    seen = 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) begin
      @(negedge clock);
      seen = seen | (cycle_valid === 1'b1) | (prog_wr === 1'b1);
    end
    chk(done === 1'b1 && busy === 1'b0, "host job never ended");
  endtask
  // one start and field from the host, straps settled first
  task automatic nib(input logic [3:0] s, input logic [3:0] f);
    repeat (4) @(negedge clock);
    s_nib = s;
    f_nib = f;
    exp = want(s, f, id_strap, mode_sel);
    cmd_start = 1'b1;
    @(negedge clock);
    cmd_start = 1'b0;
    wait_done();
    chk(seen === exp[3], "claim mismatch");
    if (exp[3])
      chk(cycle_kind === exp[1:0] && cycle_write === exp[2] &&
          field_nib === f, "decode mismatch");
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    // every start code, random then matching fields
    for (int i = 0; i < 32; i++) begin
      rnd = $random(seed);
      id_strap = rnd[7:4];
      op_busy = rnd[8];
      if (i < 16)
        nib(i[3:0], rnd[3:0]);
      else if (i[0])
        nib(4'h0, {2'h1, rnd[1:0]});
      else
        nib(rnd[9] ? 4'hd : 4'he, id_strap);
      cyc_done = 1'b1;
      @(negedge clock);
      cyc_done = 1'b0;
      @(negedge clock);
      chk(standby === ~op_busy && u_fhp_if.dev_lane_oe === 1'b0,
          "not idle");
    end
    // boot id claim, drive lanes, then abort
    id_strap = 4'h0;
    op_busy = 1'b0;
    nib(4'hd, 4'h0);
    lane_data = rnd[13:10];
    lane_drive_req = 1'b1;
    repeat (2) @(negedge clock);
    chk(u_fhp_if.nibble_lanes === lane_data &&
        lanes_seen === lane_data && claimed === 1'b1, "lane drive");
    cmd_abort = 1'b1;
    @(negedge clock);
    cmd_abort = 1'b0;
    wait_done();
    chk(claimed === 1'b0 && seen === 1'b0 &&
        u_fhp_if.dev_lane_oe === 1'b0, "abort");
    lane_drive_req = 1'b0;
    // programming port
    mode_sel = 1'b1;
    repeat (8) @(negedge clock);
    chk(prog_mode === 1'b1 && full_feature_en === 1'b0,
        "mode");
    for (int k = 0; k < 6; k++) begin
      rnd = $random(seed);
      h_addr = rnd[17:0];
      h_wdata = rnd[25:18];
      d_rdata = rnd[31:24];
      status_in = rnd[31:24] ^ rnd[7:0];
      prog_write = k[0];
      prog_go = 1'b1;
      @(negedge clock);
      prog_go = 1'b0;
      wait_done();
      chk(seen === prog_write, "write pulse");
      if (prog_write)
        chk(d_addr === h_addr && d_wdata === h_wdata,
            "write");
      else
        chk(h_rdata === d_rdata, "read");
      chk(ready_busy === status_in[7], "ready busy");
    end
    // clock enable low: host ignores a job, device holds its pins
    clk_en = 1'b0;
    status_in = ~status_in;
    prog_go = 1'b1;
    repeat (4) @(negedge clock);
    prog_go = 1'b0;
    chk(busy === 1'b0 && ready_busy === ~status_in[7], "frozen");
    clk_en = 1'b1;
    nib(4'hd, id_strap);
    tally_and_finish();
  end
endmodule
